/* src/ifs_pkg.sv */
package ifs_pkg;
  // Register subaddresses
  localparam logic [7:0] IFS_OFS_BANK = 8'h0E;
  localparam logic [7:0] IFS_OFS_SENSE_ONE = 8'h5D;
  localparam logic [7:0] IFS_OFS_SENSE_TWO = 8'h5E;
  localparam logic [7:0] IFS_OFS_STATUS = 8'h5F;
  // Field positions
  localparam int IFS_PD_BIT = 6;
  localparam int IFS_THR_LSB = 2;
  localparam int IFS_THR_W = 3;
  localparam int IFS_BANK_LSB = 5;
  // Values after reset
  localparam logic IFS_PD_RESET = 1'b1;
  localparam logic [2:0] IFS_THR_RESET = 3'h3;
  localparam logic [1:0] IFS_BANK_RESET = 2'h0;
  // Bank codes written to the bank register
  localparam logic [7:0] IFS_BANK_PRIMARY_WR = 8'h00;
  localparam logic [7:0] IFS_BANK_SECOND_WR = 8'h40;
  localparam logic [1:0] IFS_BANK_PRIMARY = 2'h0;
  // Two-wire slave address, low bit taken from the address select pin
  localparam logic [6:0] IFS_DEV_ADDR_BASE = 7'h20;
  localparam logic [3:0] IFS_BITS_PER_BYTE = 4'h8;
  localparam int IFS_NUM_SENSE = 2;

  typedef enum logic [2:0] {
    IFS_ST_IDLE = 3'b000,
    IFS_ST_ADDR = 3'b001,
    IFS_ST_ACK_ADDR = 3'b010,
    IFS_ST_SUB = 3'b011,
    IFS_ST_ACK_DATA = 3'b100,
    IFS_ST_WDATA = 3'b101,
    IFS_ST_RDATA = 3'b110,
    IFS_ST_RACK = 3'b111
  } ifs_state_t;
endpackage

/* src/ifs_sense_channel.sv */
`timescale 1ns/10ps
`default_nettype none
module ifs_sense_channel (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Comparator and control
  input wire logic i_comparator_above,
  input wire logic i_power_down,
  input wire logic i_clear,
  // Sticky fault
  output logic o_fault
);
  logic sync1_reg;
  logic sync2_reg;
  logic fault_reg;

  // Comparator is asynchronous to the clock
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= i_comparator_above; // R12
      sync2_reg <= sync1_reg;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      fault_reg <= 1'b0;
    end else if (sync2_reg && !i_power_down) begin // R13
      fault_reg <= 1'b1; // R12
    end else if (i_clear) begin
      fault_reg <= 1'b0;
    end
  end

  assign o_fault = fault_reg;
endmodule
`default_nettype wire

/* src/ifs_top.sv */
// Function
// R01: Sense one power-down bit, resets high
// R02: Sense one threshold code, resets to 011
// R03: Sense one above threshold raises fault
// R04: Host powers up sense one first
// R05: Sense two power-down bit, resets high
// R06: Sense two threshold code, resets to 011
// R07: Sense two above threshold raises fault
// R08: Host powers up sense two first
// R09: Bank register selects primary or second bank
// R10: Answer slave address 0x40 or 0x42
// R11: Fault drives low interrupt, status shows input
// R12: Synchronize comparators, sticky status until cleared
// R13: Powered-down input never reports a fault; only new sets are blocked, a fault latched before power-down stays set
`timescale 1ns/10ps
`default_nettype none
module ifs_top
  import ifs_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Two-wire bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_addr_select,
  // Comparator results
  input wire logic i_sense_input_one_above,
  input wire logic i_sense_input_two_above,
  // Analog sense controls
  output logic o_sense_one_power_down,
  output logic [2:0] o_sense_one_threshold,
  output logic o_sense_two_power_down,
  output logic [2:0] o_sense_two_threshold,
  // Interrupt
  output logic o_interrupt_request_n
);
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic [1:0] asel_sync_reg;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  ifs_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] sub_reg;
  logic rw_reg;
  logic nack_reg;
  logic oe_reg;
  logic sda_out_reg;
  logic wr_fire;
  logic pd_one_reg;
  logic pd_two_reg;
  logic [2:0] thr_one_reg;
  logic [2:0] thr_two_reg;
  logic [1:0] bank_reg;
  logic [IFS_NUM_SENSE-1:0] above;
  logic [IFS_NUM_SENSE-1:0] pd_vec;
  logic [IFS_NUM_SENSE-1:0] clear_vec;
  logic [IFS_NUM_SENSE-1:0] fault;
  logic irq_n_reg;
  logic [6:0] dev_addr;
  logic [7:0] rd_cur;
  logic [7:0] rd_next;

  // Pins pass two flops; third stage only for edge detection
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      asel_sync_reg <= 2'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
      sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
      asel_sync_reg <= {asel_sync_reg[0], i_addr_select};
    end
  end

  assign scl = scl_sync_reg[1];
  assign sda = sda_sync_reg[1];
  assign scl_rise = scl && !scl_sync_reg[2];
  assign scl_fall = !scl && scl_sync_reg[2];
  assign bus_start = scl && scl_sync_reg[2] && !sda && sda_sync_reg[2];
  assign bus_stop = scl && scl_sync_reg[2] && sda && !sda_sync_reg[2];
  assign dev_addr = {IFS_DEV_ADDR_BASE[6:1], asel_sync_reg[1]}; // R10

  function automatic logic [7:0] ctrl_byte(input logic pd, input logic [2:0] thr);
    logic [7:0] v;
    v = 8'h00;
    v[IFS_PD_BIT] = pd;
    v[IFS_THR_LSB +: IFS_THR_W] = thr;
    return v;
  endfunction

  // Unmapped subaddresses and other banks, except the bank register, read as zero
  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (addr == IFS_OFS_BANK) begin
      v[IFS_BANK_LSB +: 2] = bank_reg;
    end else if (bank_reg == IFS_BANK_PRIMARY) begin // R09
      unique case (addr)
        IFS_OFS_SENSE_ONE: v = ctrl_byte(pd_one_reg, thr_one_reg);
        IFS_OFS_SENSE_TWO: v = ctrl_byte(pd_two_reg, thr_two_reg);
        IFS_OFS_STATUS: v[IFS_NUM_SENSE-1:0] = fault; // R11
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // Read bytes for this subaddress and the next, so the sequencer needs no function select
  always_comb begin
    rd_cur = read_reg(sub_reg);
    rd_next = read_reg(sub_reg + 8'h01);
  end

  assign wr_fire = (state_reg == IFS_ST_WDATA) && scl_fall && (bit_cnt_reg == IFS_BITS_PER_BYTE);

  // Two-wire slave sequencer
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_reg <= IFS_ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      sub_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (bus_start) begin
      state_reg <= IFS_ST_ADDR;
      bit_cnt_reg <= 4'h0;
      oe_reg <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= IFS_ST_IDLE;
      oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        IFS_ST_IDLE: begin
          oe_reg <= 1'b0;
        end
        IFS_ST_ADDR, IFS_ST_SUB, IFS_ST_WDATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == IFS_BITS_PER_BYTE) begin
            if (state_reg == IFS_ST_ADDR) begin
              if (shift_reg[7:1] == dev_addr) begin // R10
                rw_reg <= shift_reg[0];
                oe_reg <= 1'b1;
                state_reg <= IFS_ST_ACK_ADDR;
              end else begin
                state_reg <= IFS_ST_IDLE;
              end
            end else begin
              if (state_reg == IFS_ST_SUB) begin
                sub_reg <= shift_reg;
              end else begin
                sub_reg <= sub_reg + 8'h01;
              end
              oe_reg <= 1'b1;
              state_reg <= IFS_ST_ACK_DATA;
            end
          end
        end
        IFS_ST_ACK_ADDR: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              tx_reg <= rd_cur;
              oe_reg <= !rd_cur[7];
              state_reg <= IFS_ST_RDATA;
            end else begin
              oe_reg <= 1'b0;
              state_reg <= IFS_ST_SUB;
            end
          end
        end
        IFS_ST_ACK_DATA: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            oe_reg <= 1'b0;
            state_reg <= IFS_ST_WDATA;
          end
        end
        IFS_ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == IFS_BITS_PER_BYTE) begin
              oe_reg <= 1'b0;
              state_reg <= IFS_ST_RACK;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              oe_reg <= !tx_reg[6];
            end
          end
        end
        IFS_ST_RACK: begin
          if (scl_rise) begin
            nack_reg <= sda;
          end else if (scl_fall) begin
            // Master NACK ends the read; address wraps at the top
            if (nack_reg) begin
              state_reg <= IFS_ST_IDLE;
            end else begin
              sub_reg <= sub_reg + 8'h01;
              tx_reg <= rd_next;
              oe_reg <= !rd_next[7];
              bit_cnt_reg <= 4'h0;
              state_reg <= IFS_ST_RDATA;
            end
          end
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
    end
  end

  // Bank register exists in every bank
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      bank_reg <= IFS_BANK_RESET;
    end else if (wr_fire && sub_reg == IFS_OFS_BANK) begin
      bank_reg <= shift_reg[IFS_BANK_LSB +: 2]; // R09
    end
  end

  // Sense control registers, primary bank only
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pd_one_reg <= IFS_PD_RESET; // R01
      thr_one_reg <= IFS_THR_RESET; // R02
      pd_two_reg <= IFS_PD_RESET; // R05
      thr_two_reg <= IFS_THR_RESET; // R06
    end else if (wr_fire && bank_reg == IFS_BANK_PRIMARY) begin
      if (sub_reg == IFS_OFS_SENSE_ONE) begin
        pd_one_reg <= shift_reg[IFS_PD_BIT]; // R01
        thr_one_reg <= shift_reg[IFS_THR_LSB +: IFS_THR_W]; // R02
      end
      if (sub_reg == IFS_OFS_SENSE_TWO) begin
        pd_two_reg <= shift_reg[IFS_PD_BIT]; // R05
        thr_two_reg <= shift_reg[IFS_THR_LSB +: IFS_THR_W]; // R06
      end
    end
  end

  assign above = {i_sense_input_two_above, i_sense_input_one_above};
  assign pd_vec = {pd_two_reg, pd_one_reg};

  // Threshold only matters while powered up, so gating by power-down suffices
  generate
    for (genvar i = 0; i < IFS_NUM_SENSE; i++) begin : g_sense
      assign clear_vec[i] = wr_fire && bank_reg == IFS_BANK_PRIMARY
                            && sub_reg == IFS_OFS_STATUS && shift_reg[i];
      ifs_sense_channel u_chan (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_comparator_above(above[i]), // R03 R07
        .i_power_down(pd_vec[i]), // R04 R08 R13
        .i_clear(clear_vec[i]),
        .o_fault(fault[i])
      );
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= !(|fault); // R11
    end
  end

  assign o_sda_out = sda_out_reg;
  assign o_sda_oe = oe_reg;
  assign o_sense_one_power_down = pd_one_reg;
  assign o_sense_one_threshold = thr_one_reg;
  assign o_sense_two_power_down = pd_two_reg;
  assign o_sense_two_threshold = thr_two_reg;
  assign o_interrupt_request_n = irq_n_reg;
endmodule
`default_nettype wire

/* bench/ifs_fault_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module ifs_fault_checker (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Pins watched
  input wire logic i_scl,
  input wire logic i_sense_input_one_above,
  input wire logic i_sense_input_two_above,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_sense_one_power_down,
  input wire logic [2:0] o_sense_one_threshold,
  input wire logic o_sense_two_power_down,
  input wire logic [2:0] o_sense_two_threshold,
  input wire logic o_interrupt_request_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // Long enough to cross the synchronizer
  sequence s_hit_one;
    (!o_sense_one_power_down && i_sense_input_one_above) [*3];
  endsequence
  sequence s_hit_two;
    (!o_sense_two_power_down && i_sense_input_two_above) [*3];
  endsequence
  // No bus fall lately, so no register write can land
  sequence s_scl_quiet;
    i_scl [*6];
  endsequence
  a_rst_one_vals: assert property (
    $fell(i_reset) |-> o_sense_one_power_down && o_sense_one_threshold == 3'h3)
    else $error("sense one reset values wrong");
  a_rst_two_vals: assert property (
    $fell(i_reset) |-> o_sense_two_power_down && o_sense_two_threshold == 3'h3)
    else $error("sense two reset values wrong");
  a_hit_one_irq: assert property (
    s_hit_one |-> ##[0:3] !o_interrupt_request_n)
    else $error("sense one fault did not pull irq low");
  a_hit_two_irq: assert property (
    s_hit_two |-> ##[0:3] !o_interrupt_request_n)
    else $error("sense two fault did not pull irq low");
  a_pd_no_irq: assert property (
    (o_sense_one_power_down && o_sense_two_power_down) [*3] ##0 o_interrupt_request_n
      |=> o_interrupt_request_n)
    else $error("irq raised while both inputs powered down");
  a_irq_sticky: assert property (
    s_scl_quiet ##0 !o_interrupt_request_n |=> !o_interrupt_request_n)
    else $error("irq released without a bus write");
  a_ctrl_stable: assert property (
    s_scl_quiet |=> $stable(o_sense_one_power_down) && $stable(o_sense_one_threshold)
      && $stable(o_sense_two_power_down) && $stable(o_sense_two_threshold))
    else $error("control output changed with bus quiet");
  a_oe_rise_low: assert property (
    $rose(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("data pull started outside clock low");
  a_oe_hold_high: assert property (
    i_scl && $past(i_scl) |-> $stable(o_sda_oe) && !o_sda_out)
    else $error("data pull changed during clock high");
endmodule
`default_nettype wire

/* bench/ifs_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ifs_host_model (
  // Clock and bus wire
  input wire logic i_mclk,
  input wire logic i_sda_wire,
  // Master pins, 1 means released
  output logic o_scl,
  output logic o_sda
);
  logic [7:0] dev_wr;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    dev_wr = 8'h40;
  end
  task automatic w(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // Data moves only with clock low, else it would frame
  task automatic clk_bit(input logic b, output logic s);
    o_scl = 1'b0;
    w(3);
    o_sda = b;
    w(3);
    o_scl = 1'b1;
    w(3);
    s = i_sda_wire;
    w(3);
  endtask
  // Clock low first, so a repeated start never lands on a pulled ACK bit
  task automatic start();
    o_scl = 1'b0;
    w(3);
    o_sda = 1'b1;
    w(3);
    o_scl = 1'b1;
    w(6);
    o_sda = 1'b0;
    w(6);
  endtask
  task automatic stop();
    logic s;
    clk_bit(1'b0, s);
    o_sda = 1'b1;
    w(6);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    put(dev_wr, a0);
    put(sub, a1);
    put(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // Single byte read, ended by a no-acknowledge
  task automatic rd(input logic [7:0] sub, output logic [7:0] d, output logic ok);
    logic a0, a1, a2, s;
    start();
    put(dev_wr, a0);
    put(sub, a1);
    start();
    put(dev_wr | 8'h01, a2);
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(1'b1, s);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ifs_pkg::*;
  logic i_mclk, i_reset, i_scl, i_sda, o_sda_out, o_sda_oe, i_addr_select, host_sda, ok;
  logic i_sense_input_one_above, i_sense_input_two_above, o_interrupt_request_n;
  logic o_sense_one_power_down, o_sense_two_power_down;
  logic [2:0] o_sense_one_threshold, o_sense_two_threshold;
  logic [7:0] rdat, wdat, sub;
  int err_count, n_compared, cyc, seed;
  // Open drain with pull-up
  assign i_sda = host_sda & (o_sda_oe ? o_sda_out : 1'b1);
  ifs_top ifs_top_inst (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .i_addr_select(i_addr_select),
    .i_sense_input_one_above(i_sense_input_one_above),
    .i_sense_input_two_above(i_sense_input_two_above),
    .o_sense_one_power_down(o_sense_one_power_down),
    .o_sense_one_threshold(o_sense_one_threshold),
    .o_sense_two_power_down(o_sense_two_power_down),
    .o_sense_two_threshold(o_sense_two_threshold),
    .o_interrupt_request_n(o_interrupt_request_n)
  );
  ifs_host_model ifs_host_model_inst (.i_mclk(i_mclk), .i_sda_wire(i_sda), .o_scl(i_scl),
    .o_sda(host_sda));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  function automatic logic [7:0] ctrl_exp(input logic [7:0] d);
    return d & 8'h5C;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    ifs_host_model_inst.wr(a, d, ok);
    chk({7'h0, ok}, 8'h01);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    ifs_host_model_inst.rd(a, rdat, ok);
    chk({7'h0, ok}, 8'h01);
    chk(rdat, exp);
  endtask
  task automatic do_reset();
    i_reset = 1'b1;
    repeat (5) @(negedge i_mclk);
    i_reset = 1'b0;
    repeat (3) @(negedge i_mclk);
    chk({o_sense_one_power_down, o_sense_one_threshold, o_sense_two_power_down,
      o_sense_two_threshold}, 8'hBB);
    chk({7'h0, o_interrupt_request_n}, 8'h01);
  endtask
  // Comparator held past the synchronizer, then dropped
  task automatic pulse(input int k);
    @(negedge i_mclk);
    if (k == 0) i_sense_input_one_above = 1'b1;
    else i_sense_input_two_above = 1'b1;
    repeat (4) @(negedge i_mclk);
    i_sense_input_one_above = 1'b0;
    i_sense_input_two_above = 1'b0;
    repeat (6) @(negedge i_mclk);
  endtask
  // Hang guard, about two and a half times the expected run
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    seed = 24886;
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    i_addr_select = 1'b0;
    i_sense_input_one_above = 1'b0;
    i_sense_input_two_above = 1'b0;
    do_reset();
    reg_rd(IFS_OFS_SENSE_ONE, 8'h4C);
    reg_rd(IFS_OFS_SENSE_TWO, 8'h4C);
    i_addr_select = 1'b1;
    repeat (4) @(negedge i_mclk);
    ifs_host_model_inst.wr(IFS_OFS_SENSE_ONE, 8'h00, ok);
    chk({7'h0, ok}, 8'h00);
    ifs_host_model_inst.dev_wr = 8'h42;
    reg_rd(IFS_OFS_SENSE_ONE, 8'h4C);
    for (int i = 0; i < 16; i++) begin
      wdat = $random(seed);
      wdat[4:2] = i[3:1];
      sub = i[0] ? IFS_OFS_SENSE_TWO : IFS_OFS_SENSE_ONE;
      reg_wr(sub, wdat);
      chk(i[0] ? {o_sense_two_power_down, o_sense_two_threshold, 4'h0} : {o_sense_one_power_down,
        o_sense_one_threshold, 4'h0}, {wdat[6], wdat[4:2], 4'h0});
      reg_rd(sub, ctrl_exp(wdat));
    end
    for (int k = 0; k < 2; k++) begin
      sub = k[0] ? IFS_OFS_SENSE_TWO : IFS_OFS_SENSE_ONE;
      reg_wr(sub, 8'h4C);
      pulse(k);
      chk({7'h0, o_interrupt_request_n}, 8'h01);
      reg_rd(IFS_OFS_STATUS, 8'h00);
      reg_wr(sub, 8'h0C);
      pulse(k);
      chk({7'h0, o_interrupt_request_n}, 8'h00);
      reg_rd(IFS_OFS_STATUS, 8'h01 << k);
      reg_wr(IFS_OFS_STATUS, 8'hFF);
      chk({7'h0, o_interrupt_request_n}, 8'h01);
      reg_rd(IFS_OFS_STATUS, 8'h00);
    end
    reg_wr(IFS_OFS_BANK, IFS_BANK_SECOND_WR);
    reg_rd(IFS_OFS_BANK, 8'h40);
    reg_wr(IFS_OFS_SENSE_ONE, 8'h5C);
    chk({4'h0, o_sense_one_power_down, o_sense_one_threshold}, 8'h03);
    reg_rd(IFS_OFS_SENSE_ONE, 8'h00);
    reg_wr(IFS_OFS_BANK, IFS_BANK_PRIMARY_WR);
    reg_rd(IFS_OFS_SENSE_ONE, 8'h0C);
    do_reset();
    reg_rd(IFS_OFS_SENSE_ONE, 8'h4C);
    print_verdict();
  end
endmodule
bind ifs_top ifs_fault_checker ifs_fault_checker_inst (
  .i_mclk(i_mclk),
  .i_reset(i_reset),
  .i_scl(i_scl),
  .i_sense_input_one_above(i_sense_input_one_above),
  .i_sense_input_two_above(i_sense_input_two_above),
  .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe),
  .o_sense_one_power_down(o_sense_one_power_down),
  .o_sense_one_threshold(o_sense_one_threshold),
  .o_sense_two_power_down(o_sense_two_power_down),
  .o_sense_two_threshold(o_sense_two_threshold),
  .o_interrupt_request_n(o_interrupt_request_n)
);
`default_nettype wire
